// ### rtl/mma_arbiter.sv
// Multi-master two-wire bus monitor, arbitration, slave address acknowledge, APB registers
//
// Function
// - Reset or disable clears start and stop flags
// - Flags follow the latest start or stop
// - Bus free: stop seen, or neither seen
// - Stop while busy raises serial interrupt
// - Master checks SDA only when releasing high
// - Lost arbitration releases SDA and SCL
// - Slave keeps receiving after lost arbitration
// - Addressed after address-phase loss: acknowledge
// - Data-phase loss flags whole-transfer resend
// - Cleared clock release holds SCL low
// - SCL pulled only after sampled low
// - SCL low until released by everyone
`timescale 1ns/1ns
module mma_arbiter (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire pins, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // Interrupt
  output logic             irq
);

  mma_pkg::mma_state_t q;
  mma_pkg::mma_state_t next_q;

  logic                      sda;
  logic                      scl;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;
  logic                      bus_free;
  logic                      busy;
  logic                      arb_lost;
  logic                      setup;
  logic                      access;
  logic                      mapped;
  logic [7:0]                byte_in;
  logic [mma_pkg::EV_W-1:0]  ev_set;
  logic [mma_pkg::EV_W-1:0]  ev_clr;
  logic [31:0]               rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions, seen through the second synchroniser stage only
  assign sda       = q.sda_y[1];
  assign scl       = q.scl_y[1];
  assign scl_rise  = scl & ~q.scl_q;
  assign scl_fall  = ~scl & q.scl_q;
  assign start_det = q.en & scl & q.scl_q & q.sda_q & ~sda;
  assign stop_det  = q.en & scl & q.scl_q & ~q.sda_q & sda;
  assign bus_free  = q.stop_seen | ~(q.start_seen | q.stop_seen);
  assign busy      = q.start_seen & ~q.stop_seen;
  assign byte_in   = {q.sh[6:0], sda};
  // Sampled at the rising edge so a foreign start with SCL high is not a loss
  assign arb_lost  = q.en & q.mst_en & scl_rise & q.dir_sda & ~q.ack_drv & ~sda;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = access;
  assign mapped  = (paddr == mma_pkg::OFS_CTRL) | (paddr == mma_pkg::OFS_DIR)
                 | (paddr == mma_pkg::OFS_STAT) | (paddr == mma_pkg::OFS_EVT)
                 | (paddr == mma_pkg::OFS_MASK) | (paddr == mma_pkg::OFS_ADDR)
                 | (paddr == mma_pkg::OFS_RXD);
  assign pslverr = access & ~mapped;
  assign prdata  = q.rdata;

  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      mma_pkg::OFS_CTRL: begin
        rd_mux[mma_pkg::CTRL_EN]    = q.en;
        rd_mux[mma_pkg::CTRL_SLV]   = q.slv_en;
        rd_mux[mma_pkg::CTRL_MST]   = q.mst_en;
        rd_mux[mma_pkg::CTRL_CKREL] = q.clock_release_bit;
      end
      mma_pkg::OFS_DIR: begin
        rd_mux[mma_pkg::DIR_SDA] = q.dir_sda;
        rd_mux[mma_pkg::DIR_SCL] = q.dir_scl;
      end
      mma_pkg::OFS_STAT: begin
        rd_mux[mma_pkg::ST_ACK]   = q.ack_drv;
        rd_mux[mma_pkg::ST_SCL]   = scl;
        rd_mux[mma_pkg::ST_SDA]   = sda;
        rd_mux[mma_pkg::ST_START] = q.start_seen;
        rd_mux[mma_pkg::ST_STOP]  = q.stop_seen;
        rd_mux[mma_pkg::ST_FREE]  = bus_free;
        rd_mux[mma_pkg::ST_RETRY] = q.retry;
      end
      mma_pkg::OFS_EVT:  rd_mux[mma_pkg::EV_W-1:0] = q.evt;
      mma_pkg::OFS_MASK: rd_mux[mma_pkg::EV_W-1:0] = q.mask;
      mma_pkg::OFS_ADDR: rd_mux[6:0] = q.own;
      mma_pkg::OFS_RXD:  rd_mux[7:0] = q.rx;
      default:           rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;
    ev_set = '0;
    // Only the bits software actually saw are cleared; a new event wins
    ev_clr = (access & ~pwrite & (paddr == mma_pkg::OFS_EVT)) ? q.rdata[mma_pkg::EV_W-1:0] : '0;
    next_q.sda_y = {q.sda_y[0], sda_i};
    next_q.scl_y = {q.scl_y[0], scl_i};
    next_q.sda_q = sda;
    next_q.scl_q = scl;
    if (setup) begin
      next_q.rdata = rd_mux;
    end
    if (access & pwrite) begin
      case (paddr)
        mma_pkg::OFS_CTRL: begin
          next_q.en                = pwdata[mma_pkg::CTRL_EN];
          next_q.slv_en            = pwdata[mma_pkg::CTRL_SLV];
          next_q.mst_en            = pwdata[mma_pkg::CTRL_MST];
          next_q.clock_release_bit = pwdata[mma_pkg::CTRL_CKREL];
        end
        mma_pkg::OFS_DIR: begin
          next_q.dir_sda = pwdata[mma_pkg::DIR_SDA];
          next_q.dir_scl = pwdata[mma_pkg::DIR_SCL];
          // Restarting on a free bus is the resend
          if (bus_free) begin
            next_q.retry = 1'b0;
          end
        end
        mma_pkg::OFS_MASK: next_q.mask = pwdata[mma_pkg::EV_W-1:0];
        mma_pkg::OFS_ADDR: next_q.own  = pwdata[6:0];
        default: begin
        end
      endcase
    end
    // Clock hold: pulls SCL only once the line is already low
    if (q.clock_release_bit | ~q.en) begin
      next_q.hold_scl = 1'b0;
    end else if (~scl) begin
      next_q.hold_scl = 1'b1;
    end
    // Bit and byte tracking; runs whether or not this end won the bus
    if (scl_rise) begin
      next_q.sh = byte_in;
      if (q.cnt != mma_pkg::BIT_END) begin
        next_q.cnt = q.cnt + 4'h1;
      end
      if (q.cnt == mma_pkg::BIT_LAST) begin
        next_q.rx        = byte_in;
        ev_set[mma_pkg::EV_RX] = 1'b1;
        if (q.in_addr & q.slv_en & (q.sh[6:0] == q.own)) begin
          next_q.match             = 1'b1;
          ev_set[mma_pkg::EV_ADDR] = 1'b1;
        end
      end
    end
    if (scl_fall) begin
      if (q.cnt == mma_pkg::BIT_ACK) begin
        next_q.ack_drv = q.match;
        next_q.match   = 1'b0;
      end else if (q.cnt == mma_pkg::BIT_END) begin
        next_q.cnt     = 4'h0;
        next_q.ack_drv = 1'b0;
        next_q.in_addr = 1'b0;
      end
    end
    if (start_det) begin
      next_q.start_seen = 1'b1;
      next_q.stop_seen  = 1'b0;
      next_q.cnt        = 4'h0;
      next_q.in_addr    = 1'b1;
      next_q.match      = 1'b0;
      next_q.ack_drv    = 1'b0;
      ev_set[mma_pkg::EV_START] = 1'b1;
    end
    if (stop_det) begin
      next_q.stop_seen  = 1'b1;
      next_q.start_seen = 1'b0;
      next_q.cnt        = 4'h0;
      next_q.in_addr    = 1'b0;
      next_q.match      = 1'b0;
      next_q.ack_drv    = 1'b0;
      ev_set[mma_pkg::EV_STOP] = busy;
    end
    if (arb_lost) begin
      next_q.dir_sda = 1'b1;
      next_q.dir_scl = 1'b1;
      ev_set[mma_pkg::EV_ARB] = 1'b1;
      if (~q.in_addr) begin
        next_q.retry = 1'b1;
      end
    end
    if (~q.en) begin
      next_q.start_seen = 1'b0;
      next_q.stop_seen  = 1'b0;
      next_q.cnt        = 4'h0;
      next_q.in_addr    = 1'b0;
      next_q.match      = 1'b0;
      next_q.ack_drv    = 1'b0;
    end
    next_q.evt = (q.evt & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= mma_pkg::STATE_RST;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and interrupt
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  assign sda_oe_n = ~(q.en & (~q.dir_sda | q.ack_drv));
  assign scl_oe_n = ~(q.en & (~q.dir_scl | q.hold_scl));
  assign irq      = |(q.evt & q.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dis_clear;
    !q.en |=> !q.start_seen && !q.stop_seen;
  endproperty
  a_dis_clear: assert property (p_dis_clear) else $error("flags not cleared");

  property p_start_flag;
    start_det && !stop_det |=> q.start_seen && !q.stop_seen && !bus_free;
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start flag wrong");

  property p_stop_free;
    stop_det && q.en |=> q.stop_seen && !q.start_seen && bus_free;
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("stop flag wrong");

  property p_stop_irq;
    stop_det && busy |=> q.evt[mma_pkg::EV_STOP] && (irq || !q.mask[mma_pkg::EV_STOP]);
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop interrupt missing");

  property p_cmp_high;
    arb_lost |-> q.dir_sda && scl && !sda;
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("compare while driving");

  property p_release;
    arb_lost |=> sda_oe_n && q.dir_scl && q.evt[mma_pkg::EV_ARB];
  endproperty
  a_release: assert property (p_release) else $error("lines not released");

  property p_hold_late;
    $rose(q.hold_scl) |-> $past(q.scl_y[1]) == 1'b0;
  endproperty
  a_hold_late: assert property (p_hold_late) else $error("SCL pulled while high");

  property p_hold_drv;
    q.en && !q.clock_release_bit && q.hold_scl |-> !scl_oe_n;
  endproperty
  a_hold_drv: assert property (p_hold_drv) else $error("SCL not held");

  property p_release_clk;
    q.clock_release_bit ##1 q.clock_release_bit |-> !q.hold_scl;
  endproperty
  a_release_clk: assert property (p_release_clk) else $error("SCL hold stuck");

  property p_ack;
    scl_fall && q.cnt == mma_pkg::BIT_ACK && q.match && !start_det && !stop_det && q.en
      |=> !sda_oe_n;
  endproperty
  a_ack: assert property (p_ack) else $error("address not acknowledged");

  c_arb:  cover property (arb_lost && !q.in_addr);
  c_ack:  cover property ($rose(q.ack_drv));
  c_stop: cover property (stop_det && busy);
  c_hold: cover property ($rose(q.hold_scl));

endmodule

// ### rtl/mma_pkg.sv
// Constants, register map and state type of the multi-master two-wire monitor
package mma_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIR  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_EVT  = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_RXD  = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_SLV   = 1;
  localparam int CTRL_MST   = 2;
  localparam int CTRL_CKREL = 3;
  localparam int DIR_SCL    = 6;
  localparam int DIR_SDA    = 7;
  localparam int ST_ACK     = 0;
  localparam int ST_SCL     = 1;
  localparam int ST_SDA     = 2;
  localparam int ST_START   = 3;
  localparam int ST_STOP    = 4;
  localparam int ST_FREE    = 5;
  localparam int ST_RETRY   = 6;
  localparam int EV_START   = 0;
  localparam int EV_STOP    = 1;
  localparam int EV_RX      = 2;
  localparam int EV_ARB     = 3;
  localparam int EV_ADDR    = 4;
  localparam int EV_W       = 6;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_END  = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the block
  typedef struct packed {
    logic [1:0]      sda_y;
    logic [1:0]      scl_y;
    logic            sda_q;
    logic            scl_q;
    logic            start_seen;
    logic            stop_seen;
    logic            en;
    logic            slv_en;
    logic            mst_en;
    logic            clock_release_bit;
    logic            dir_sda;
    logic            dir_scl;
    logic            hold_scl;
    logic            retry;
    logic [3:0]      cnt;
    logic            in_addr;
    logic            match;
    logic            ack_drv;
    logic [7:0]      sh;
    logic [7:0]      rx;
    logic [6:0]      own;
    logic [EV_W-1:0] evt;
    logic [EV_W-1:0] mask;
    logic [31:0]     rdata;
  } mma_state_t;

  // Lines released, clock released, synchronisers high, everything else clear
  localparam mma_state_t STATE_RST = '{sda_y: 2'h3, scl_y: 2'h3, sda_q: 1'b1, scl_q: 1'b1,
    clock_release_bit: 1'b1, dir_sda: 1'b1, dir_scl: 1'b1, default: '0};

endpackage

// ### test/mma_bus_peer.sv
// Behavioural peer master on the two-wire bus, lines pulled up
`timescale 1ns/1ns
module mma_bus_peer (
  // Bench clock; the peer moves just after its rising edges
  input  wire logic clk,
  // Design side of the open-drain pins
  input  wire logic dut_scl_o,
  input  wire logic dut_scl_oe_n,
  input  wire logic dut_sda_o,
  input  wire logic dut_sda_oe_n,
  // Resolved wire levels
  output logic      scl,
  output logic      sda
);
  logic p_scl = 1'b1;
  logic p_sda = 1'b1;

  ////////////////////////////////////////
  // Wired-AND: a released line floats up to the pull-up level
  assign scl = p_scl & (dut_scl_oe_n | dut_scl_o);
  assign sda = p_sda & (dut_sda_oe_n | dut_sda_o);

  ////////////////////////////////////////
  // Caller starts only on a free bus; ten clocks make one 80 ns bit time
  task automatic start();
    @(posedge clk);
    p_sda <= 1'b0;
    repeat (5) @(posedge clk);
    p_scl <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic bit_io(input logic b, output logic got);
    int n;
    @(posedge clk);
    p_sda <= b;
    repeat (2) @(posedge clk);
    p_scl <= 1'b1;
    n = 0;
    // A slower party may stretch the low phase
    do begin
      @(posedge clk);
      n++;
    end while (scl !== 1'b1 && n < 100);
    if (scl !== 1'b1) begin
      test_mma_arbiter.bad_count++;
      test_mma_arbiter.end_of_test();
    end
    repeat (4) @(posedge clk);
    got = sda;
    p_scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic stop();
    @(posedge clk);
    p_sda <= 1'b0;
    repeat (2) @(posedge clk);
    p_scl <= 1'b1;
    repeat (5) @(posedge clk);
    p_sda <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
endmodule

// ### test/test_mma_arbiter.sv
// Self-checking bench: APB register access and two-wire traffic with a peer
`timescale 1ns/1ns
module test_mma_arbiter;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda;
  logic        scl_o;
  logic        scl_oe_n;
  logic        sda_o;
  logic        sda_oe_n;
  logic        irq;
  logic        ack;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          cmp_count = 0;

  ////////////////////////////////////////
  mma_arbiter i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));
  mma_bus_peer i_peer (.clk(clk), .dut_scl_o(scl_o), .dut_scl_oe_n(scl_oe_n),
    .dut_sda_o(sda_o), .dut_sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic end_of_test();
    $display("Compared %0d, mismatched %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Sends nb bits MSB first, then releases SDA for the acknowledge bit
  task automatic sbits(input logic [7:0] b, input int nb);
    logic x;
    for (int i = nb - 1; i >= 0; i--) begin
      i_peer.bit_io(b[i], x);
    end
    i_peer.bit_io(1'b1, ack);
  endtask

  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end

  ////////////////////////////////////////
  initial begin
    rst_n   <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(mma_pkg::OFS_CTRL, 32'h08);
    rdc(mma_pkg::OFS_DIR, 32'hc0);
    rdc(mma_pkg::OFS_STAT, 32'h26);
    rdc(8'h1c, 32'h0);
    chk(err, 1'b1);
    // Addressed as slave, interrupt masked then unmasked
    apb(1'b1, mma_pkg::OFS_CTRL, 32'h0b);
    apb(1'b1, mma_pkg::OFS_ADDR, 32'h2a);
    i_peer.start();
    rdc(mma_pkg::OFS_STAT, 32'h08);
    chk(irq, 1'b0);
    apb(1'b1, mma_pkg::OFS_MASK, 32'h1f);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    sbits(8'h54, 8);
    chk(ack, 1'b0);
    i_peer.stop();
    rdc(mma_pkg::OFS_STAT, 32'h36);
    rdc(mma_pkg::OFS_EVT, 32'h17);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rdc(mma_pkg::OFS_RXD, 32'h54);
    // Lost in the address phase, then in the data phase
    apb(1'b1, mma_pkg::OFS_CTRL, 32'h0f);
    apb(1'b1, mma_pkg::OFS_DIR, 32'hc0);
    i_peer.start();
    i_peer.bit_io(1'b0, ack);
    sbits(8'h54, 7);
    chk(ack, 1'b0);
    rdc(mma_pkg::OFS_EVT, 32'h1d);
    rdc(mma_pkg::OFS_STAT, 32'h0c);
    apb(1'b1, mma_pkg::OFS_DIR, 32'h40);
    i_peer.bit_io(1'b0, ack);
    rdc(mma_pkg::OFS_EVT, 32'h0);
    apb(1'b1, mma_pkg::OFS_DIR, 32'hc0);
    i_peer.bit_io(1'b0, ack);
    rdc(mma_pkg::OFS_EVT, 32'h08);
    rdc(mma_pkg::OFS_STAT, 32'h48);
    rdc(mma_pkg::OFS_DIR, 32'hc0);
    chk({sda_oe_n, scl_oe_n, sda_o, scl_o}, 4'hc);
    sbits(8'h00, 6);
    chk(ack, 1'b1);
    i_peer.stop();
    rdc(mma_pkg::OFS_EVT, 32'h0e);
    apb(1'b1, mma_pkg::OFS_DIR, 32'hc0);
    rdc(mma_pkg::OFS_STAT, 32'h36);
    // Clock release held clear, then set while the peer still holds SCL
    apb(1'b1, mma_pkg::OFS_CTRL, 32'h07);
    repeat (10) @(posedge clk);
    chk(scl_oe_n, 1'b1);
    i_peer.p_scl <= 1'b0;
    repeat (5) @(posedge clk);
    i_peer.p_scl <= 1'b1;
    repeat (5) @(posedge clk);
    chk(scl, 1'b0);
    chk(scl_oe_n, 1'b0);
    i_peer.p_scl <= 1'b0;
    apb(1'b1, mma_pkg::OFS_CTRL, 32'h0f);
    repeat (10) @(posedge clk);
    chk(scl, 1'b0);
    chk(scl_oe_n, 1'b1);
    i_peer.p_scl <= 1'b1;
    repeat (2) @(posedge clk);
    chk(scl, 1'b1);
    // Disable in mid-transfer clears the flags
    i_peer.start();
    apb(1'b1, mma_pkg::OFS_CTRL, 32'h08);
    rdc(mma_pkg::OFS_STAT, 32'h20);
    i_peer.stop();
    end_of_test();
  end
endmodule
